// file: core/nos_pkg.sv
// Purpose: Shared constants for the no-op, OR and stack decode/execute core
// Assumes: One instruction cycle per i_mclk edge, 4-bit data nibbles
// Notes: Opcode patterns are matched with the masks given beside them
package nos_pkg;

  // Widths of the core's data paths
  localparam int NIB_W = 4;   // One data nibble
  localparam int PAIR_W = 8;  // Register pair, two nibbles
  localparam int ADDR_W = 12; // Data memory nibble address
  localparam int PC_W = 12;   // Program counter

  // One-byte opcodes
  localparam logic [7:0] OP_NOP = 8'ha0;      // No operation
  localparam logic [7:0] OP_OR_MEM = 8'h3a;   // Accumulator OR memory
  localparam logic [7:0] OP_PFX_ACC = 8'hdd;  // Prefix: imm OR, bank pair
  localparam logic [7:0] OP_PFX_PAIR = 8'hdc; // Prefix: pair OR forms

  // Stack pair ops: 00101 pp x, low bit picks push
  localparam logic [7:0] OP_STK_MASK = 8'hf8; // Fixed upper five bits
  localparam logic [7:0] OP_STK_VAL = 8'h28;  // Value of upper five bits

  // Second bytes
  localparam logic [7:0] OP2_IMM_MASK = 8'hf0; // Immediate in low nibble
  localparam logic [7:0] OP2_IMM_VAL = 8'h20;  // 0010 dddd
  localparam logic [7:0] OP2_POP_BANKS = 8'h66;  // Restore bank pair
  localparam logic [7:0] OP2_PUSH_BANKS = 8'h67; // Save bank pair
  localparam logic [7:0] OP2_PAIR_MASK = 8'hf9; // Pair select in [2:1]
  localparam logic [7:0] OP2_XACC_OR_PAIR = 8'h28; // 00101 pp 0
  localparam logic [7:0] OP2_PAIR_OR_XACC = 8'h20; // 00100 pp 0

  // Index of the memory pointer pair among the general pairs
  localparam logic [1:0] PTR_IDX = 2'h3;

  // Stack lives in data memory bank zero
  localparam logic [3:0] STACK_BANK = 4'h0;

  // Reset values
  localparam logic [7:0] SP_RST = 8'h00;
  localparam logic [11:0] PC_RST = 12'h000;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [7:0] SP_STEP = 8'h02; // Stack moves two nibbles

  // Decode states: waiting for an opcode, or for the second byte
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_ACC2 = 2'b01,
    ST_PAIR2 = 2'b10
  } nos_state_t;

endpackage

// file: core/nos_pair_file.sv
// Purpose: Four general register pairs with two read ports, one write port
// Assumes: Reads are combinational, write lands on the clock edge
// Notes: Small enough that flops beat a memory macro
`timescale 1ns/1ns
`default_nettype none
module nos_pair_file (
  input wire logic i_mclk,          // Core clock
  input wire logic i_rst_n,         // Synchronous reset, active low
  input wire logic [1:0] i_ra_idx,  // Read port A pair select
  output logic [7:0] o_ra_data,     // Read port A data
  input wire logic [1:0] i_rb_idx,  // Read port B pair select
  output logic [7:0] o_rb_data,     // Read port B data
  input wire logic i_we,            // Write enable
  input wire logic [1:0] i_w_idx,   // Write pair select
  input wire logic [7:0] i_w_data   // Write data, high nibble on top
);

  logic [7:0] pair_reg [4]; // Pair storage

  // Reads see the value before this cycle's write
  assign o_ra_data = pair_reg[i_ra_idx];
  assign o_rb_data = pair_reg[i_rb_idx];

  // Clear on reset, otherwise a single write per cycle
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < 4; i++)
      begin
        pair_reg[i] <= 8'h00;
      end
    end
    else if (i_we)
    begin
      pair_reg[i_w_idx] <= i_w_data;
    end
  end

endmodule
`default_nettype wire

// file: core/nos_core.sv
// Purpose: Decode and execute no-op, OR forms, and stack pop/push
// Assumes: Data memory answers reads in the same cycle (combinational)
// Notes: One opcode byte is taken per cycle whenever i_op_valid is high
// Function
// - NOP: one byte, only program counter advances
// - Two-byte immediate OR into accumulator, 2 cycles
// - OR memory at pointer pair into accumulator
// - OR selected pair into extended accumulator
// - OR extended accumulator into selected pair
// - Only destination written; source left unchanged
// - Pop pair from stack, pointer plus two
// - Pop bank selects from stack, two cycles
// - Push pair to stack, pointer minus two
// - Push bank selects to stack, two cycles
`timescale 1ns/1ns
`default_nettype none
module nos_core (
  input wire logic i_mclk,              // Core clock, 10 MHz
  input wire logic i_rst_n,             // Synchronous reset, active low
  input wire logic i_op_valid,          // Opcode byte present
  input wire logic [7:0] i_op_byte,     // Opcode byte
  output logic o_op_ready,              // Byte taken when valid
  output logic [11:0] o_pc,             // Program counter
  output logic [3:0] o_acc,             // Accumulator
  output logic [3:0] o_ext,             // Extension nibble of the pair
  output logic [7:0] o_sp,              // Stack pointer
  output logic [3:0] o_reg_bank_sel,    // Register bank select
  output logic [3:0] o_mem_bank_sel,    // Memory bank select
  output logic o_unknown,               // Byte not handled here
  output logic [11:0] o_ram_addr_a,     // Data memory address A
  output logic [11:0] o_ram_addr_b,     // Data memory address B
  input wire logic [3:0] i_ram_rdata_a, // Read data at address A
  input wire logic [3:0] i_ram_rdata_b, // Read data at address B
  output logic o_ram_we,                // Write both addresses
  output logic [3:0] o_ram_wdata_a,     // Write data for address A
  output logic [3:0] o_ram_wdata_b      // Write data for address B
);

  nos_pkg::nos_state_t state_reg; // Decode state
  nos_pkg::nos_state_t state_next;
  logic [11:0] pc_reg;            // Program counter
  logic [3:0] acc_reg;            // Accumulator
  logic [3:0] ext_reg;            // Extension nibble
  logic [7:0] sp_reg;             // Stack pointer
  logic [3:0] rbs_reg;            // Register bank select
  logic [3:0] mbs_reg;            // Memory bank select
  logic unknown_reg;              // Unhandled byte pulse
  logic [7:0] sel_pair;           // Pair picked by the opcode
  logic [7:0] ptr_pair;           // Memory pointer pair
  logic [1:0] sel_idx;            // Pair select bits
  logic take;                     // A byte is taken this cycle
  logic f_nop, f_orhl, f_pop, f_push;     // Fetch-state decodes
  logic a_imm, a_popsb, a_pushsb;         // After accumulator prefix
  logic p_earr, p_rrea;                   // After pair prefix
  logic pair_we;                          // Pair file write
  logic [7:0] pair_wdata;                 // Pair file write data

  // Masked opcode compare, used by the stack, immediate and pair decodes below
  function automatic logic op_is(input logic [7:0] b, input logic [7:0] m,
                                 input logic [7:0] v);
    op_is = (b & m) == v;
  endfunction

  // Decoder never stalls; every valid byte is taken
  assign o_op_ready = 1'b1;
  assign take = i_op_valid;
  assign sel_idx = i_op_byte[2:1];

  // Fetch-state decodes
  assign f_nop = take && state_reg == nos_pkg::ST_FETCH &&
    i_op_byte == nos_pkg::OP_NOP;
  assign f_orhl = take && state_reg == nos_pkg::ST_FETCH &&
    i_op_byte == nos_pkg::OP_OR_MEM;
  assign f_pop = take && state_reg == nos_pkg::ST_FETCH &&
    op_is(i_op_byte, nos_pkg::OP_STK_MASK, nos_pkg::OP_STK_VAL) &&
    !i_op_byte[0];
  assign f_push = take && state_reg == nos_pkg::ST_FETCH &&
    op_is(i_op_byte, nos_pkg::OP_STK_MASK, nos_pkg::OP_STK_VAL) &&
    i_op_byte[0];
  // Second-byte decodes
  assign a_imm = take && state_reg == nos_pkg::ST_ACC2 &&
    op_is(i_op_byte, nos_pkg::OP2_IMM_MASK, nos_pkg::OP2_IMM_VAL);
  assign a_popsb = take && state_reg == nos_pkg::ST_ACC2 &&
    i_op_byte == nos_pkg::OP2_POP_BANKS;
  assign a_pushsb = take && state_reg == nos_pkg::ST_ACC2 &&
    i_op_byte == nos_pkg::OP2_PUSH_BANKS;
  assign p_earr = take && state_reg == nos_pkg::ST_PAIR2 &&
    op_is(i_op_byte, nos_pkg::OP2_PAIR_MASK, nos_pkg::OP2_XACC_OR_PAIR);
  assign p_rrea = take && state_reg == nos_pkg::ST_PAIR2 &&
    op_is(i_op_byte, nos_pkg::OP2_PAIR_MASK, nos_pkg::OP2_PAIR_OR_XACC);

  // Pair writes: pop loads, or OR result lands in the chosen pair
  assign pair_we = f_pop || p_rrea;
  assign pair_wdata = f_pop ? {i_ram_rdata_b, i_ram_rdata_a}
    : (sel_pair | {ext_reg, acc_reg});

  nos_pair_file u_pairs (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ra_idx(sel_idx),
    .o_ra_data(sel_pair),
    .i_rb_idx(nos_pkg::PTR_IDX),
    .o_rb_data(ptr_pair),
    .i_we(pair_we),
    .i_w_idx(sel_idx),
    .i_w_data(pair_wdata)
  );

  // Data memory ports: stack ops use bank zero, OR uses the pointer pair
  always_comb
  begin
    o_ram_addr_a = {nos_pkg::STACK_BANK, sp_reg};
    o_ram_addr_b = {nos_pkg::STACK_BANK, 8'(sp_reg + 8'h01)};
    o_ram_we = 1'b0;
    o_ram_wdata_a = sel_pair[7:4];
    o_ram_wdata_b = sel_pair[3:0];
    if (f_orhl)
    begin
      o_ram_addr_a = {mbs_reg, ptr_pair};
    end
    else if (f_push || a_pushsb)
    begin
      // High part one below the pointer, low part two below
      o_ram_addr_a = {nos_pkg::STACK_BANK, 8'(sp_reg - 8'h01)};
      o_ram_addr_b = {nos_pkg::STACK_BANK, 8'(sp_reg - 8'h02)};
      o_ram_we = 1'b1;
      if (a_pushsb)
      begin
        o_ram_wdata_a = mbs_reg;
        o_ram_wdata_b = rbs_reg;
      end
    end
  end

  // Next decode state; an unknown second byte returns to fetch
  always_comb
  begin
    state_next = state_reg;
    if (take)
    begin
      unique case (state_reg)
        nos_pkg::ST_FETCH:
        begin
          if (i_op_byte == nos_pkg::OP_PFX_ACC)
            state_next = nos_pkg::ST_ACC2;
          else if (i_op_byte == nos_pkg::OP_PFX_PAIR)
            state_next = nos_pkg::ST_PAIR2;
        end
        nos_pkg::ST_ACC2: state_next = nos_pkg::ST_FETCH;
        nos_pkg::ST_PAIR2: state_next = nos_pkg::ST_FETCH;
        default: state_next = nos_pkg::ST_FETCH;
      endcase
    end
  end

  // Decode state register
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      state_reg <= nos_pkg::ST_FETCH;
    else
      state_reg <= state_next;
  end

  // Program counter steps once per taken byte, NOP included
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      pc_reg <= nos_pkg::PC_RST;
    else if (take)
      pc_reg <= 12'(pc_reg + 12'h001);
  end

  // Accumulator: only OR forms targeting it write it
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      acc_reg <= nos_pkg::NIB_RST;
      ext_reg <= nos_pkg::NIB_RST;
    end
    else if (a_imm)
      acc_reg <= acc_reg | i_op_byte[3:0];
    else if (f_orhl)
      acc_reg <= acc_reg | i_ram_rdata_a;
    else if (p_earr)
      {ext_reg, acc_reg} <= {ext_reg, acc_reg} | sel_pair;
  end

  // Stack pointer moves by two on every pop or push
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      sp_reg <= nos_pkg::SP_RST;
    else if (f_pop || a_popsb)
      sp_reg <= 8'(sp_reg + nos_pkg::SP_STEP);
    else if (f_push || a_pushsb)
      sp_reg <= 8'(sp_reg - nos_pkg::SP_STEP);
  end

  // Bank selects restored from the stack
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      rbs_reg <= nos_pkg::NIB_RST;
      mbs_reg <= nos_pkg::NIB_RST;
    end
    else if (a_popsb)
    begin
      rbs_reg <= i_ram_rdata_a;
      mbs_reg <= i_ram_rdata_b;
    end
  end

  // Flags bytes outside this decoder, so a wider core can pick them up
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      unknown_reg <= 1'b0;
    else
      unknown_reg <= take && !(f_nop || f_orhl || f_pop || f_push ||
        a_imm || a_popsb || a_pushsb || p_earr || p_rrea ||
        (state_reg == nos_pkg::ST_FETCH &&
         (i_op_byte == nos_pkg::OP_PFX_ACC ||
          i_op_byte == nos_pkg::OP_PFX_PAIR)));
  end

  assign o_pc = pc_reg;
  assign o_acc = acc_reg;
  assign o_ext = ext_reg;
  assign o_sp = sp_reg;
  assign o_reg_bank_sel = rbs_reg;
  assign o_mem_bank_sel = mbs_reg;
  assign o_unknown = unknown_reg;

  // All checks sample on the core clock and rest while reset is held
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  // NOP leaves accumulator, extension nibble and pointer alone but moves the PC
  chk_nop_only_pc: assert property (
    f_nop |=> $stable(acc_reg) && $stable(sp_reg) && $stable(ext_reg) &&
      pc_reg == 12'($past(pc_reg) + 12'h001))
    else $error("NOP changed state other than PC");

  chk_imm_or_acc: assert property (
    (take && state_reg == nos_pkg::ST_FETCH &&
     i_op_byte == nos_pkg::OP_PFX_ACC) ##1 a_imm
    |=> acc_reg == ($past(acc_reg) | $past(i_op_byte[3:0])))
    else $error("Immediate OR gave wrong accumulator");

  chk_mem_or_acc: assert property (
    f_orhl |-> o_ram_addr_a[7:0] == ptr_pair ##1
      acc_reg == ($past(acc_reg) | $past(i_ram_rdata_a)))
    else $error("Memory OR gave wrong accumulator");

  chk_xacc_or_pair: assert property (
    p_earr |=> {ext_reg, acc_reg} == ($past({ext_reg, acc_reg}) |
      $past(sel_pair)))
    else $error("Pair OR into extended accumulator wrong");

  chk_pair_or_src: assert property (
    p_rrea |-> pair_we && pair_wdata == (sel_pair | {ext_reg, acc_reg})
      ##1 $stable({ext_reg, acc_reg}))
    else $error("OR into pair touched its source");

  chk_pop_pair_sp: assert property (
    f_pop |-> pair_wdata == {i_ram_rdata_b, i_ram_rdata_a} &&
      o_ram_addr_b[7:0] == 8'(sp_reg + 8'h01)
      ##1 sp_reg == 8'($past(sp_reg) + 8'h02))
    else $error("Pair pop wrong data or pointer");

  chk_pop_banks: assert property (
    a_popsb |=> rbs_reg == $past(i_ram_rdata_a) &&
      mbs_reg == $past(i_ram_rdata_b) &&
      sp_reg == 8'($past(sp_reg) + 8'h02))
    else $error("Bank pop wrong");

  chk_push_pair_sp: assert property (
    f_push |-> o_ram_we && o_ram_addr_a[7:0] == 8'(sp_reg - 8'h01) &&
      o_ram_wdata_b == sel_pair[3:0]
      ##1 sp_reg == 8'($past(sp_reg) - 8'h02))
    else $error("Pair push wrong data or pointer");

  chk_push_banks: assert property (
    a_pushsb |-> o_ram_we && o_ram_wdata_a == mbs_reg &&
      o_ram_wdata_b == rbs_reg &&
      o_ram_addr_b[7:0] == 8'(sp_reg - 8'h02))
    else $error("Bank push wrong");

endmodule
`default_nettype wire

// file: bench/nos_ram_model.sv
// Purpose: Data memory model facing the decode core, nibble wide
// Assumes: Reads answer in the same cycle, writes land on the edge
// Notes: The bench seeds mem directly before reset is released
`timescale 1ns/1ns
`default_nettype none
module nos_ram_model (
  input wire logic i_mclk,          // Core clock
  input wire logic [11:0] i_addr_a, // Address A
  input wire logic [11:0] i_addr_b, // Address B
  output logic [3:0] o_rdata_a,     // Data at address A
  output logic [3:0] o_rdata_b,     // Data at address B
  input wire logic i_we,            // Write both addresses
  input wire logic [3:0] i_wdata_a, // Write data A
  input wire logic [3:0] i_wdata_b  // Write data B
);
  // Whole data space; plain always so the bench may seed it
  logic [3:0] mem [4096];
  // Combinational read, as the core relies on it
  assign o_rdata_a = mem[i_addr_a];
  assign o_rdata_b = mem[i_addr_b];
  // Both nibbles land at the same edge
  always @(posedge i_mclk)
  begin
    if (i_we)
    begin
      mem[i_addr_a] <= i_wdata_a;
      mem[i_addr_b] <= i_wdata_b;
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Random self-checking bench for the decode core
// Assumes: One byte taken per edge with valid high, no stalls
// Notes: A bench model predicts state after every taken byte
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic i_mclk, i_rst_n, i_op_valid, o_op_ready, o_unknown, o_ram_we;
  logic [7:0] i_op_byte, o_sp;
  logic [11:0] o_pc, o_ram_addr_a, o_ram_addr_b, last_pc;
  logic [3:0] o_acc, o_ext, o_reg_bank_sel, o_mem_bank_sel;
  logic [3:0] rd_a, rd_b, o_ram_wdata_a, o_ram_wdata_b;
  // Model state, updated as each byte is driven
  logic [11:0] m_pc;
  logic [7:0] m_sp;
  logic [3:0] m_acc, m_ext, m_rbs, m_mbs;
  logic [7:0] m_pair [4];
  logic m_unk;
  logic [1:0] m_st; // 0 opcode, 1 after acc prefix, 2 after pair prefix
  logic [3:0] sh [4096]; // Shadow of data memory
  logic [39:0] exp_q [$]; // Expected snapshots, oldest first
  logic [31:0] rnd;
  int bad_count, checks;

  nos_core i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_op_valid(i_op_valid), .i_op_byte(i_op_byte),
    .o_op_ready(o_op_ready), .o_pc(o_pc), .o_acc(o_acc), .o_ext(o_ext),
    .o_sp(o_sp), .o_reg_bank_sel(o_reg_bank_sel),
    .o_mem_bank_sel(o_mem_bank_sel), .o_unknown(o_unknown),
    .o_ram_addr_a(o_ram_addr_a), .o_ram_addr_b(o_ram_addr_b),
    .i_ram_rdata_a(rd_a), .i_ram_rdata_b(rd_b), .o_ram_we(o_ram_we),
    .o_ram_wdata_a(o_ram_wdata_a), .o_ram_wdata_b(o_ram_wdata_b));
  nos_ram_model i_ram (.i_mclk(i_mclk), .i_addr_a(o_ram_addr_a),
    .i_addr_b(o_ram_addr_b), .o_rdata_a(rd_a), .o_rdata_b(rd_b),
    .i_we(o_ram_we), .i_wdata_a(o_ram_wdata_a), .i_wdata_b(o_ram_wdata_b));

  // Free-running 10 MHz clock
  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  // Galois shift register for all random choices
  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction

  // Packed views of expected and actual visible state
  function logic [39:0] exp_snap();
    exp_snap = {2'h0, 1'b1, m_unk, m_pc, m_acc, m_ext, m_sp, m_rbs, m_mbs};
  endfunction
  function logic [39:0] act_snap();
    act_snap = {2'h0, o_op_ready, o_unknown, o_pc, o_acc, o_ext, o_sp,
      o_reg_bank_sel, o_mem_bank_sel};
  endfunction

  task cmp(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task results;
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Stack helpers on the model; stack lives in bank zero
  task push2(input logic [3:0] hi, input logic [3:0] lo);
    sh[{nos_pkg::STACK_BANK, m_sp - 8'd1}] = hi;
    sh[{nos_pkg::STACK_BANK, m_sp - 8'd2}] = lo;
    m_sp = m_sp - nos_pkg::SP_STEP;
  endtask
  task pop2(output logic [7:0] v);
    v = {sh[{nos_pkg::STACK_BANK, m_sp + 8'd1}],
      sh[{nos_pkg::STACK_BANK, m_sp}]};
    m_sp = m_sp + nos_pkg::SP_STEP;
  endtask

  // Predict the effect of one taken byte
  task step(input logic [7:0] b);
    logic [7:0] v;
    logic [7:0] ea;
    m_pc = m_pc + 12'h001;
    m_unk = 1'b0;
    ea = {m_ext, m_acc};
    if (m_st == 2'd1)
    begin
      m_st = 2'd0;
      if ((b & nos_pkg::OP2_IMM_MASK) == nos_pkg::OP2_IMM_VAL)
        m_acc = m_acc | b[3:0];
      else if (b == nos_pkg::OP2_POP_BANKS)
      begin
        pop2(v);
        {m_mbs, m_rbs} = v;
      end
      else if (b == nos_pkg::OP2_PUSH_BANKS)
        push2(m_mbs, m_rbs);
      else
        m_unk = 1'b1;
    end
    else if (m_st == 2'd2)
    begin
      m_st = 2'd0;
      if ((b & nos_pkg::OP2_PAIR_MASK) == nos_pkg::OP2_XACC_OR_PAIR)
        {m_ext, m_acc} = ea | m_pair[b[2:1]];
      else if ((b & nos_pkg::OP2_PAIR_MASK) == nos_pkg::OP2_PAIR_OR_XACC)
        m_pair[b[2:1]] = m_pair[b[2:1]] | ea;
      else
        m_unk = 1'b1;
    end
    else if (b == nos_pkg::OP_OR_MEM)
      m_acc = m_acc | sh[{m_mbs, m_pair[nos_pkg::PTR_IDX]}];
    else if (b == nos_pkg::OP_PFX_ACC)
      m_st = 2'd1;
    else if (b == nos_pkg::OP_PFX_PAIR)
      m_st = 2'd2;
    else if ((b & nos_pkg::OP_STK_MASK) == nos_pkg::OP_STK_VAL)
    begin
      if (b[0])
        push2(m_pair[b[2:1]][7:4], m_pair[b[2:1]][3:0]);
      else
        pop2(m_pair[b[2:1]]);
    end
    else if (b != nos_pkg::OP_NOP)
      m_unk = 1'b1;
  endtask

  // Drive one byte at the falling edge, note its outcome, maybe idle
  task send(input logic [7:0] b);
    @(negedge i_mclk);
    i_op_valid <= 1'b1;
    i_op_byte <= b;
    step(b);
    exp_q.push_back(exp_snap());
    rnd = lfsr(rnd);
    if (rnd[0])
    begin
      @(negedge i_mclk);
      i_op_valid <= 1'b0;
      i_op_byte <= rnd[15:8];
    end
  endtask
  task send2(input logic [7:0] a, input logic [7:0] b);
    send(a);
    send(b);
  endtask

  // Every program counter move is one taken byte: check its snapshot
  always @(negedge i_mclk)
  begin
    if (i_rst_n === 1'b1 && o_pc !== last_pc)
    begin
      last_pc = o_pc;
      if (exp_q.size() == 0)
        cmp(act_snap(), 40'h0);
      else
        cmp(act_snap(), exp_q.pop_front());
    end
  end

  // Main sequence
  initial
  begin
    i_rst_n = 1'b0;
    i_op_valid = 1'b0;
    i_op_byte = 8'h00;
    rnd = 32'hf73c;
    {bad_count, checks, last_pc, m_pc, m_sp, m_unk, m_st} = '0;
    {m_acc, m_ext, m_rbs, m_mbs} = '0;
    for (int i = 0; i < 4; i++)
      m_pair[i] = 8'h00;
    // Seed memory so pops and pointer reads see varied data
    for (int i = 0; i < 4096; i++)
    begin
      rnd = lfsr(rnd);
      sh[i] = rnd[3:0];
      i_ram.mem[i] = rnd[3:0];
    end
    repeat (8) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst_n <= 1'b1;
    @(negedge i_mclk);
    cmp(act_snap(), exp_snap());
    repeat (3) send(nos_pkg::OP_NOP);
    repeat (700)
    begin
      rnd = lfsr(rnd);
      case (rnd[18:16])
      3'd0: send(nos_pkg::OP_NOP);
      3'd1: send2(nos_pkg::OP_PFX_ACC, {4'h2, rnd[11:8]});
      3'd2: send(nos_pkg::OP_OR_MEM);
      3'd3: send2(nos_pkg::OP_PFX_PAIR, {5'b00101,rnd[9:8],1'b0});
      3'd4: send2(nos_pkg::OP_PFX_PAIR, {5'b00100,rnd[9:8],1'b0});
      3'd5: send({5'b00101, rnd[9:8], rnd[10]});
      3'd6: send2(nos_pkg::OP_PFX_ACC, {7'b0110011, rnd[10]});
      default: send(rnd[15:8]);
      endcase
    end
    @(negedge i_mclk);
    i_op_valid <= 1'b0;
    repeat (3) @(negedge i_mclk);
    cmp(40'(exp_q.size()), 40'h0);
    // Stack bank must hold exactly what pushes wrote
    for (int i = 0; i < 256; i++)
      cmp({36'h0, i_ram.mem[i]}, {36'h0, sh[i]});
    results();
  end

  // Run should take about 1600 cycles; cut a hang well beyond that
  initial
  begin
    repeat (20000) @(posedge i_mclk);
    bad_count++;
    results();
  end
endmodule
`default_nettype wire
